// File: core/i2c_flags_divider.sv
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module i2c_flags_divider (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Bus engine events, same clock domain
  input wire logic transmitting,
  input wire logic ack_seen,
  input wire logic nack_seen,
  input wire logic general_call,
  input wire logic arb_lost_seen,
  input wire logic bus_busy,
  // Outputs
  output logic scl_out,
  output logic scl_oe,
  output logic nack_req,
  output logic lost_req,
  output logic slave_receiver
);
  // Flag state
  logic nack_reg, nack_next;
  logic lost_reg, lost_next;

  // Divider and prescaler state
  logic [15:0] low_reg, low_next;
  logic [15:0] high_reg, high_next;
  logic [7:0] psc_reg, psc_next;

  // Mode state and derived levels
  logic [15:0] mode_reg, mode_next;
  logic in_reset;
  logic is_master;
  logic run_div;

  // Read path and serial clock
  logic [31:0] rdata_next;
  logic [3:0] offset_d;
  logic scl_level;

  // Address compare, shared by every register select
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
    addr_is = (a == off);
  endfunction

  // Offset d for a prescaler value
  // Small prescaler settings carry a longer fixed part of each phase
  function automatic logic [3:0] offset_for(input logic [7:0] psc);
    case (psc)
      8'h00: offset_for = flag_div_pkg::d_psc0;
      8'h01: offset_for = flag_div_pkg::d_psc1;
      default: offset_for = flag_div_pkg::d_other;
    endcase
  endfunction

  // Priority code for the source register, lost ranks first
  // Only the code on show is cleared by a read, so one read clears one flag
  function automatic logic [2:0] src_code(input logic lost, input logic nack);
    if (lost) begin
      src_code = flag_div_pkg::code_lost;
    end else if (nack) begin
      src_code = flag_div_pkg::code_nack;
    end else begin
      src_code = flag_div_pkg::code_none;
    end
  endfunction

  // Transfer phases; only the access cycle acts on a register
  wire setup = psel && !penable;
  wire wr = psel && penable && pwrite;
  wire rd = psel && penable && !pwrite;

  // Register selects
  wire hit_status = addr_is(paddr, flag_div_pkg::status_off);
  wire hit_low = addr_is(paddr, flag_div_pkg::low_div_off);
  wire hit_high = addr_is(paddr, flag_div_pkg::high_div_off);
  wire hit_mode = addr_is(paddr, flag_div_pkg::mode_off);
  wire hit_src = addr_is(paddr, flag_div_pkg::source_off);
  wire hit_psc = addr_is(paddr, flag_div_pkg::prescale_off);

  // Anything else answers with an error and reads zero
  wire mapped = hit_status
    | hit_low
    | hit_high
    | hit_mode
    | hit_src
    | hit_psc;

  // Code the source register shows right now
  wire [2:0] cur_code = src_code(lost_reg, nack_reg);

  // Module held in reset while the release bit is low
  assign in_reset = !mode_reg[flag_div_pkg::release_bit];
  assign is_master = mode_reg[flag_div_pkg::master_bit];
  assign run_div = is_master && !in_reset;

  // Writing the release bit low resets both flags
  wire release_clear = wr && hit_mode && !pwdata[flag_div_pkg::release_bit];

  // Nack sources; engine events only count while transmitting
  // A general call always reports nack, whoever acknowledged
  wire nack_hit = nack_seen || (general_call && ack_seen);
  wire nack_set = !in_reset && transmitting && nack_hit;
  wire ack_clr = transmitting && ack_seen && !general_call;
  wire nack_wclr = wr && hit_status && pwdata[flag_div_pkg::nack_bit];
  wire nack_rclr = rd && hit_src && (cur_code == flag_div_pkg::code_nack);
  wire nack_clr = nack_wclr || nack_rclr || ack_clr;

  // Lost sources; a start strobe into a busy bus loses at once
  wire start_try = wr && hit_mode && pwdata[flag_div_pkg::start_bit];
  wire engine_lost = arb_lost_seen && is_master && transmitting;
  wire busy_lost = start_try && bus_busy;
  wire lost_set = !in_reset && (engine_lost || busy_lost);
  wire lost_wclr = wr && hit_status && pwdata[flag_div_pkg::lost_bit];
  wire lost_rclr = rd && hit_src && (cur_code == flag_div_pkg::code_lost);
  wire lost_clr = lost_wclr || lost_rclr;

  // Nack next value; module reset clears, then set outranks every clear
  // Set wins so an event landing on a clear is never lost to software
  always_comb begin
    nack_next = nack_reg;
    if (nack_clr) begin
      nack_next = 1'b0;
    end
    if (nack_set) begin
      nack_next = 1'b1;
    end
    if (release_clear) begin
      nack_next = 1'b0;
    end
  end

  // Lost next value, same priority as the nack flag
  always_comb begin
    lost_next = lost_reg;
    if (lost_clr) begin
      lost_next = 1'b0;
    end
    if (lost_set) begin
      lost_next = 1'b1;
    end
    if (release_clear) begin
      lost_next = 1'b0;
    end
  end

  // Mode register; the start strobe never stays set
  // A loss drops master and stop in the same cycle as the write or event
  always_comb begin
    mode_next = mode_reg;
    if (wr && hit_mode) begin
      mode_next = pwdata[15:0];
      mode_next[flag_div_pkg::start_bit] = 1'b0;
    end
    if (lost_set) begin
      mode_next[flag_div_pkg::master_bit] = 1'b0;
      mode_next[flag_div_pkg::stop_bit] = 1'b0;
    end
  end

  // Divider and prescaler registers; upper bus bits are dropped
  // Changing them while running would glitch SCL, so software waits for reset
  always_comb begin
    low_next = low_reg;
    high_next = high_reg;
    psc_next = psc_reg;
    if (wr && hit_low) begin
      low_next = pwdata[15:0];
    end
    if (wr && hit_high) begin
      high_next = pwdata[15:0];
    end
    if (wr && hit_psc) begin
      psc_next = pwdata[7:0];
    end
  end

  // Read mux; upper divider bits are zero
  // Bus busy is shown live, it belongs to the bus engine
  always_comb begin
    rdata_next = 32'h00000000;
    if (hit_status) begin
      rdata_next[flag_div_pkg::lost_bit] = lost_reg;
      rdata_next[flag_div_pkg::nack_bit] = nack_reg;
      rdata_next[flag_div_pkg::busy_bit] = bus_busy;
    end else if (hit_low) begin
      rdata_next = {16'h0000, low_reg};
    end else if (hit_high) begin
      rdata_next = {16'h0000, high_reg};
    end else if (hit_mode) begin
      rdata_next = {16'h0000, mode_reg};
    end else if (hit_src) begin
      rdata_next = {29'h00000000, cur_code};
    end else if (hit_psc) begin
      rdata_next = {24'h000000, psc_reg};
    end
  end

  // Offset d picked by prescaler value
  assign offset_d = offset_for(psc_reg);

  // Divider runs only as master out of reset; values assumed static then
  scl_divider u_scl_divider (
    .clk(clk),
    .reset(reset),
    .run(run_div),
    .low_div(low_reg),
    .high_div(high_reg),
    .offset_d(offset_d),
    .scl_level(scl_level)
  );

  // Flag registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      nack_reg <= 1'b0;
      lost_reg <= 1'b0;
    end else begin
      nack_reg <= nack_next;
      lost_reg <= lost_next;
    end
  end

  // Divider and prescaler registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      low_reg <= flag_div_pkg::div_reset;
      high_reg <= flag_div_pkg::div_reset;
      psc_reg <= flag_div_pkg::psc_reset;
    end else begin
      low_reg <= low_next;
      high_reg <= high_next;
      psc_reg <= psc_next;
    end
  end

  // Mode register; comes out of reset held in module reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode_reg <= flag_div_pkg::mode_reset;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // APB answer: ready in the access cycle, never a wait state
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
    end
  end

  // Read data latched at setup, so a clearing read still shows the old code
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prdata <= 32'h00000000;
    end else if (setup && !pwrite) begin
      prdata <= rdata_next;
    end
  end

  // Pin outputs; open drain pulls low only, one cycle behind the divider
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      scl_out <= 1'b0;
      scl_oe <= 1'b0;
    end else begin
      scl_out <= 1'b0;
      scl_oe <= run_div && !scl_level;
    end
  end

  // Request outputs follow the flags on the same edge
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      nack_req <= 1'b0;
      lost_req <= 1'b0;
    end else begin
      nack_req <= nack_next;
      lost_req <= lost_next;
    end
  end

  // Role output; a slave receiver whenever master select is low
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      slave_receiver <= 1'b1;
    end else begin
      slave_receiver <= !mode_next[flag_div_pkg::master_bit];
    end
  end
endmodule // i2c_flags_divider
`default_nettype wire

// File: core/scl_divider.sv
`timescale 1ns/1ps
`default_nettype none
module scl_divider (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Control
  input wire logic run,
  input wire logic [15:0] low_div,
  input wire logic [15:0] high_div,
  input wire logic [3:0] offset_d,
  // Serial clock level
  output logic scl_level
);
  typedef enum logic [1:0] {st_low = 2'b01, st_high = 2'b10} phase_e;
  phase_e phase_reg, phase_next;
  logic [16:0] cnt_reg, cnt_next;
  logic [16:0] low_len, high_len;
  logic last;

  // Phase lengths in module clocks, n + d
  assign low_len = {1'b0, low_div} + {13'h0000, offset_d};
  assign high_len = {1'b0, high_div} + {13'h0000, offset_d};
  assign last = (cnt_reg == 17'h00001);

  // Next phase and count; idle holds the line high
  always_comb begin
    phase_next = phase_reg;
    cnt_next = cnt_reg;
    case (phase_reg)
      st_low: begin
        if (!run) begin
          phase_next = st_high;
          cnt_next = high_len;
        end else if (last) begin
          phase_next = st_high;
          cnt_next = high_len;
        end else begin
          cnt_next = cnt_reg - 17'h00001;
        end
      end
      st_high: begin
        if (!run) begin
          cnt_next = high_len;
        end else if (last) begin
          phase_next = st_low;
          cnt_next = low_len;
        end else begin
          cnt_next = cnt_reg - 17'h00001;
        end
      end
      default: begin
        phase_next = st_high;
        cnt_next = high_len;
      end
    endcase
  end

  // State registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      phase_reg <= st_high;
      cnt_reg <= 17'h00001;
      scl_level <= 1'b1;
    end else begin
      phase_reg <= phase_next;
      cnt_reg <= cnt_next;
      scl_level <= (phase_next == st_high);
    end
  end
endmodule // scl_divider
`default_nettype wire

// File: include/flag_div_pkg.sv
package flag_div_pkg;
  // Register byte offsets
  localparam logic [7:0] status_off = 8'h08;
  localparam logic [7:0] low_div_off = 8'h0c;
  localparam logic [7:0] high_div_off = 8'h10;
  localparam logic [7:0] mode_off = 8'h24;
  localparam logic [7:0] source_off = 8'h28;
  localparam logic [7:0] prescale_off = 8'h30;
  // Status field positions
  localparam int lost_bit = 0;
  localparam int nack_bit = 1;
  localparam int busy_bit = 12;
  // Mode field positions
  localparam int stop_bit = 11;
  localparam int master_bit = 10;
  localparam int start_bit = 13;
  localparam int release_bit = 5;
  // Interrupt source codes
  localparam logic [2:0] code_none = 3'h0;
  localparam logic [2:0] code_lost = 3'h1;
  localparam logic [2:0] code_nack = 3'h2;
  // Reset values
  localparam logic [15:0] div_reset = 16'h0000;
  localparam logic [7:0] psc_reset = 8'h00;
  localparam logic [15:0] mode_reset = 16'h0000;
  // Divider offsets d
  localparam logic [3:0] d_psc0 = 4'h7;
  localparam logic [3:0] d_psc1 = 4'h6;
  localparam logic [3:0] d_other = 4'h5;
endpackage

// File: tb/bus_peer.sv
`timescale 1ns/1ps
`default_nettype none
module bus_peer (
  // Clock
  input wire logic clk,
  // Engine events toward the block
  output logic transmitting,
  output logic ack_seen,
  output logic nack_seen,
  output logic general_call,
  output logic arb_lost_seen,
  output logic bus_busy
);
  // Quiet bus until a scenario asks for traffic
  initial begin
    {transmitting, ack_seen, nack_seen, general_call, arb_lost_seen, bus_busy} = '0;
  end
  // Levels change just after an edge so the block samples them cleanly
  task automatic levels(input logic tx, input logic busy);
    @(posedge clk);
    transmitting <= tx;
    bus_busy <= busy;
  endtask
  // One-cycle event: 0 ack, 1 nack, 2 lost arbitration
  task automatic pulse(input logic [1:0] kind, input logic gcall);
    @(posedge clk);
    ack_seen <= (kind == 2'h0);
    nack_seen <= (kind == 2'h1);
    arb_lost_seen <= (kind == 2'h2);
    general_call <= gcall;
    @(posedge clk);
    {ack_seen, nack_seen, arb_lost_seen, general_call} <= '0;
  endtask
endmodule // bus_peer
`default_nettype wire

// File: tb/flag_div_properties.sv
`timescale 1ns/1ps
`default_nettype none
module flag_div_properties (
  // Watched ports
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic transmitting,
  input wire logic ack_seen,
  input wire logic nack_seen,
  input wire logic general_call,
  input wire logic arb_lost_seen,
  input wire logic bus_busy,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic nack_req,
  input wire logic lost_req,
  input wire logic slave_receiver
);
  // Start strobe written while another party holds the bus
  wire start_busy = psel && penable && pready && pwrite && bus_busy
    && paddr == flag_div_pkg::mode_off && pwdata[flag_div_pkg::start_bit];
  wire div_rd = pready && !pwrite
    && (paddr == flag_div_pkg::low_div_off || paddr == flag_div_pkg::high_div_off);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  chk_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("setup without answer");
  chk_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
  chk_err_with_ready: assert property (pslverr |-> pready) else $error("stray error");
  chk_upper_zero: assert property (div_rd |-> prdata[31:16] == 16'h0000)
    else $error("divider upper bits set");
  chk_nack_cause: assert property ($rose(nack_req) |->
    $past(transmitting && (nack_seen || general_call && ack_seen))) else $error("nack set");
  chk_ack_clears: assert property (nack_req && transmitting && ack_seen && !nack_seen
    && !general_call |=> !nack_req) else $error("ack kept nack");
  chk_lost_cause: assert property ($rose(lost_req) |-> $past(arb_lost_seen || start_busy))
    else $error("lost set");
  chk_lost_slave: assert property ($rose(lost_req) |-> slave_receiver)
    else $error("still master");
  chk_scl_quiet: assert property (slave_receiver [*3] |-> !scl_oe)
    else $error("slave drives scl");
endmodule // flag_div_properties
bind i2c_flags_divider flag_div_properties u_flag_div_properties (.clk, .reset, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .transmitting, .ack_seen,
  .nack_seen, .general_call, .arb_lost_seen, .bus_busy, .scl_out, .scl_oe, .nack_req,
  .lost_req, .slave_receiver);
`default_nettype wire

// File: tb/tb_i2c_flags_divider.sv
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_flags_divider;
  localparam logic [7:0] st_a = flag_div_pkg::status_off;
  localparam logic [7:0] md_a = flag_div_pkg::mode_off;
  localparam logic [7:0] src_a = flag_div_pkg::source_off;
  localparam logic [31:0] rel = 32'h1 << flag_div_pkg::release_bit;
  localparam logic [31:0] mas = 32'h1 << flag_div_pkg::master_bit;
  localparam logic [31:0] stop_req = 32'h1 << flag_div_pkg::stop_bit;
  localparam logic [31:0] sta = 32'h1 << flag_div_pkg::start_bit;
  logic clk, reset, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic transmitting, ack_seen, nack_seen, general_call, arb_lost_seen, bus_busy;
  logic scl_out, scl_oe, nack_req, lost_req, slave_receiver;
  logic [3:0] dv [3] = '{flag_div_pkg::d_psc0, flag_div_pkg::d_psc1, flag_div_pkg::d_other};
  int errors = 0;
  int comparisons = 0;
  int lo, hi;
  i2c_flags_divider u_i2c_flags_divider (.clk, .reset, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .transmitting, .ack_seen, .nack_seen,
    .general_call, .arb_lost_seen, .bus_busy, .scl_out, .scl_oe, .nack_req, .lost_req,
    .slave_receiver);
  bus_peer u_bus_peer (.clk, .transmitting, .ack_seen, .nack_seen, .general_call,
    .arb_lost_seen, .bus_busy);
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Flat 32-bit compare keeps unknowns from matching
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; answer taken at the edge that samples pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Starts at a fresh low phase so a partial phase is never counted
  task automatic scl(output int lo, output int hi);
    lo = 0;
    hi = 0;
    @(posedge clk);
    while (scl_oe !== 1'b0) @(posedge clk);
    while (scl_oe !== 1'b1) @(posedge clk);
    while (scl_oe === 1'b1) begin lo++; @(posedge clk); end
    while (scl_oe === 1'b0) begin hi++; @(posedge clk); end
  endtask
  task automatic end_sim;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    errors++;
    end_sim();
  end
  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    reset = 1'b1;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    apb(0, st_a, 0); check(r & 32'h3, 32'h0);
    apb(1, flag_div_pkg::low_div_off, 32'hffff_0003);
    apb(0, flag_div_pkg::low_div_off, 0); check(r, 32'h3);
    apb(1, flag_div_pkg::high_div_off, 32'habcd_0004);
    apb(0, flag_div_pkg::high_div_off, 0); check(r, 32'h4);
    // Every prescaler class: divider only changed while held in reset
    for (int i = 0; i < 3; i++) begin
      apb(1, md_a, 0);
      apb(1, flag_div_pkg::prescale_off, i);
      apb(1, md_a, rel | mas);
      scl(lo, hi);
      check(lo, 32'(3 + dv[i]));
      check(hi, 32'(4 + dv[i]));
      check({31'h0, scl_out}, 32'h0);
    end
    u_bus_peer.levels(1, 0);
    u_bus_peer.pulse(1, 0);
    apb(0, st_a, 0); check(r & 32'h3, 32'h2);
    check({31'h0, nack_req}, 32'h1);
    apb(0, src_a, 0); check(r & 32'h7, 32'(flag_div_pkg::code_nack));
    apb(0, st_a, 0); check(r & 32'h3, 32'h0);
    u_bus_peer.pulse(1, 0);
    apb(1, st_a, 0);
    apb(0, st_a, 0); check(r & 32'h3, 32'h2);
    apb(1, st_a, 32'h2);
    apb(0, st_a, 0); check(r & 32'h3, 32'h0);
    u_bus_peer.pulse(1, 0);
    u_bus_peer.pulse(0, 0);
    apb(0, st_a, 0); check(r & 32'h3, 32'h0);
    u_bus_peer.pulse(0, 1);
    apb(0, st_a, 0); check(r & 32'h3, 32'h2);
    apb(1, st_a, 32'h2);
    u_bus_peer.levels(0, 0);
    u_bus_peer.pulse(1, 0);
    apb(0, st_a, 0); check(r & 32'h3, 32'h0);
    // Lost arbitration drops master and stop request
    u_bus_peer.levels(1, 0);
    apb(1, md_a, rel | mas | stop_req);
    u_bus_peer.pulse(2, 0);
    apb(0, st_a, 0); check(r & 32'h3, 32'h1);
    check({30'h0, lost_req, slave_receiver}, 32'h3);
    apb(0, md_a, 0); check(r & (mas | stop_req), 32'h0);
    apb(0, src_a, 0); check(r & 32'h7, 32'(flag_div_pkg::code_lost));
    apb(0, st_a, 0); check(r & 32'h3, 32'h0);
    apb(1, md_a, rel | mas);
    u_bus_peer.pulse(2, 0);
    apb(1, st_a, 0);
    apb(0, st_a, 0); check(r & 32'h3, 32'h1);
    apb(1, st_a, 32'h1);
    apb(0, st_a, 0); check(r & 32'h3, 32'h0);
    apb(1, md_a, rel | mas);
    u_bus_peer.levels(1, 1);
    apb(1, md_a, rel | mas | sta);
    apb(0, st_a, 0); check(r & 32'h1003, 32'h1001);
    apb(1, md_a, 0);
    apb(0, st_a, 0); check(r & 32'h3, 32'h0);
    apb(0, 8'hfc, 0); check({r[30:0], e}, 32'h1);
    end_sim();
  end
endmodule // tb_i2c_flags_divider
`default_nettype wire
